// ### ir_timer_regs.vh
// register offsets, fields and timing constants of the ir pulse timer pair
// assumes an 8-bit register port with byte offsets 0x00..0x09
`ifndef IR_TIMER_REGS_VH
`define IR_TIMER_REGS_VH
`define ADDR_CARRIER_CTRL 2'h0
`define ADDR_COMMON_CTRL 2'h1
`define ADDR_WIDE_CTRL 2'h2
`define ADDR_SYNC_CTRL 2'h3
// own registers for counts and capture values
`define ADDR_CARRIER_HI 3'h4
`define ADDR_CARRIER_LO 3'h5
`define ADDR_WIDE_RELOAD_HI 3'h6
`define ADDR_WIDE_RELOAD_LO 3'h7
`define ADDR_CAPTURE_HI 4'h8
`define ADDR_CAPTURE_LO 4'h9
// carrier_timer_control / wide_timer_control fields
`define B_RUN 7
`define B_SINGLE 6
`define B_TIMEOUT 5
`define B_PRESC_HI 4
`define B_PRESC_LO 3
`define B_CAP_IE 2
`define B_TO_IE 1
`define B_PIN_SEL 0
// timer_pair_common_control fields
`define B_CAPTURE_MODE 7
`define B_DEMOD_SEL 6
`define B_LOGIC_HI 5
`define B_LOGIC_LO 4
`define B_OPSEL_HI 3
`define B_OPSEL_LO 2
`define B_T8_INIT 1
`define B_T16_INIT 0
// timer_sync_control field
`define B_SYNC_EN 7
// codes
`define OP_NORMAL 2'h0
`define OP_PINGPONG 2'h1
`define OP_FORCE_LO 2'h2
`define OP_FORCE_HI 2'h3
`define LG_AND 2'h0
`define LG_OR 2'h1
`define LG_NOR 2'h2
`define LG_NAND 2'h3
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define FILT_NONE 2'h0
`define FILT_4 2'h1
`define FILT_8 2'h2
`define FILT_4_CYCLES 4'h3
`define FILT_8_CYCLES 4'h7
`define PRESC_DIV1 2'h0
`define PRESC_DIV2 2'h1
`define PRESC_DIV4 2'h2
`define PRESC_MASK2 3'h1
`define PRESC_MASK4 3'h3
`define PRESC_MASK8 3'h7
`define ZERO8 8'h00
`define ZERO16 16'h0000
`define ONE16 16'h0001
`define RESET_CTRL 8'h00
`endif

// ### glitch_filter.v
// input glitch filter: output follows input only after it stays stable
// assumes input is synchronous to clk
`timescale 1ns/10ps
`include "ir_timer_regs.vh"
module glitch_filter (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire [1:0] mode,
	input wire raw,
	output reg filtered
);
	reg [3:0] stable_count;
	reg [3:0] limit;
	always @*
	begin
		case (mode)
			`FILT_4: limit = `FILT_4_CYCLES;
			`FILT_8: limit = `FILT_8_CYCLES;
			default: limit = 4'h0;
		endcase
	end
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stable_count <= 4'h0;
			filtered <= 1'b0;
		end
		else if (clk_en)
		begin
			if (raw == filtered)
				stable_count <= 4'h0;
			else if (stable_count >= limit)
			begin
				filtered <= raw;
				stable_count <= 4'h0;
			end
			else
				stable_count <= stable_count + 4'h1;
		end
	end
endmodule // glitch_filter

// ### ir_pulse_timer_control.v
// control and counting logic of the carrier/wide ir timer pair
// assumes a simple register port, strobes one cycle, synchronous pins
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`include "ir_timer_regs.vh"
// Behaviour
// - carrier output-select bit routes carrier timer to first shared pin
// - carrier control holds timeout and capture interrupt enables, reset off
// - two-bit prescale divides carrier timer clock by 1, 2, 4 or 8
// - carrier timeout flag reads 1 after timeout; write 1 clears
// - carrier count-mode bit: 0 reload continuously, 1 single pass
// - carrier run bit reads enable state; write 1 starts, 0 stops
// - enables, prescale, timeout flag reset on reset; kept over stop recovery
// - init level bits in transmit; edge-detected flags in capture, w1c
// - transmit field: normal, ping-pong, wide output forced low or high
// - capture field: glitch filter none, 4 or 8 clocks, reserved
// - transmit logic field combines outputs by AND, OR, NOR, NAND
// - capture edge field: falling, rising, both, reserved
// - transmit bit routes combined output to second shared pin
// - capture bit selects primary or alternate demodulator input
// - mode bit selects transmit (0) or capture (1) for both timers
// - wide output-select bit routes wide timer to third shared pin
// - wide control holds timeout and capture interrupt enables, reset off
// - wide timeout flag reads 1 after timeout; write 1 clears
// - wide bit: single pass in transmit, ignore edges in capture
// - sync mode aligns first carrier pulse to wide timer output
module ir_pulse_timer_control (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire demod_input_primary,
	input wire demod_input_alternate,
	input wire port_out_first,
	input wire port_out_second,
	input wire port_out_third,
	output reg first_shared_pin,
	output reg second_shared_pin,
	output reg third_shared_pin,
	output reg carrier_timeout_irq,
	output reg carrier_capture_irq,
	output reg wide_timeout_irq,
	output reg wide_capture_irq
);
	reg [7:0] carrier_timer_control;
	reg [7:0] timer_pair_common_control;
	reg [7:0] wide_timer_control;
	reg [7:0] timer_sync_control;
	reg [7:0] carrier_high_count;
	reg [7:0] carrier_low_count;
	reg [15:0] wide_reload;
	reg [15:0] capture_value;
	reg [7:0] carrier_timer;
	reg [15:0] wide_timer;
	reg [2:0] presc;
	reg carrier_timer_output;
	reg wide_timer_output_level;
	reg pingpong_turn;
	reg sync_wait;
	reg demod_prev;
	reg fall_flag;
	reg rise_flag;
	reg next_fall;
	reg next_rise;
	reg [2:0] presc_mask;
	reg wide_out;
	reg combined;
	reg carrier_tick;
	reg edge_hit;
	wire capture_mode;
	wire [1:0] opsel;
	wire [1:0] logic_sel;
	wire demod_raw;
	wire demod;
	wire wr_carrier;
	wire wr_common;
	wire wr_wide;
	wire carrier_run;
	wire wide_run;
	wire carrier_expire;
	wire wide_expire;
	wire is_fall;
	wire is_rise;

	assign capture_mode = timer_pair_common_control[`B_CAPTURE_MODE];
	assign opsel = timer_pair_common_control[`B_OPSEL_HI:`B_OPSEL_LO];
	assign logic_sel = timer_pair_common_control[`B_LOGIC_HI:`B_LOGIC_LO];
	assign demod_raw = timer_pair_common_control[`B_DEMOD_SEL] ?
		demod_input_alternate : demod_input_primary;
	assign wr_carrier = wr && addr == {2'h0, `ADDR_CARRIER_CTRL};
	assign wr_common = wr && addr == {2'h0, `ADDR_COMMON_CTRL};
	assign wr_wide = wr && addr == {2'h0, `ADDR_WIDE_CTRL};
	assign carrier_run = carrier_timer_control[`B_RUN];
	assign wide_run = wide_timer_control[`B_RUN];
	assign carrier_expire = carrier_run && !capture_mode && carrier_tick &&
		!sync_wait && carrier_timer == `ZERO8;
	assign wide_expire = wide_run && !capture_mode &&
		wide_timer == `ZERO16;
	assign is_fall = demod_prev && !demod;
	assign is_rise = !demod_prev && demod;

	glitch_filter u_filter (
		.clk(clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.mode(capture_mode ? opsel : `FILT_NONE),
		.raw(demod_raw),
		.filtered(demod)
	);

	always @*
	begin
		case (carrier_timer_control[`B_PRESC_HI:`B_PRESC_LO])
			`PRESC_DIV1: presc_mask = 3'h0;
			`PRESC_DIV2: presc_mask = `PRESC_MASK2;
			`PRESC_DIV4: presc_mask = `PRESC_MASK4;
			default: presc_mask = `PRESC_MASK8;
		endcase
		carrier_tick = (presc & presc_mask) == presc_mask;
		case (opsel)
			`OP_FORCE_LO: wide_out = 1'b0;
			`OP_FORCE_HI: wide_out = 1'b1;
			default: wide_out = wide_timer_output_level;
		endcase
		case (logic_sel)
			`LG_AND: combined = carrier_timer_output & wide_out;
			`LG_OR: combined = carrier_timer_output | wide_out;
			`LG_NOR: combined = ~(carrier_timer_output | wide_out);
			default: combined = ~(carrier_timer_output & wide_out);
		endcase
		case (wdata[`B_LOGIC_HI:`B_LOGIC_LO])
			default: edge_hit = 1'b0;
		endcase
		case (logic_sel)
			`EDGE_FALL: edge_hit = is_fall;
			`EDGE_RISE: edge_hit = is_rise;
			`EDGE_BOTH: edge_hit = is_fall | is_rise;
			default: edge_hit = 1'b0;
		endcase
		if (wide_timer_control[`B_SINGLE])
			edge_hit = 1'b0;
		next_fall = fall_flag;
		next_rise = rise_flag;
		if (wr_common && wdata[`B_T16_INIT])
			next_fall = 1'b0;
		if (wr_common && wdata[`B_T8_INIT])
			next_rise = 1'b0;
		if (capture_mode && wide_run && edge_hit && is_fall)
			next_fall = 1'b1;
		if (capture_mode && wide_run && edge_hit && is_rise)
			next_rise = 1'b1;
	end

	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			carrier_timer_control <= `RESET_CTRL;
			timer_pair_common_control <= `RESET_CTRL;
			wide_timer_control <= `RESET_CTRL;
			timer_sync_control <= `RESET_CTRL;
			carrier_high_count <= `ZERO8;
			carrier_low_count <= `ZERO8;
			wide_reload <= `ZERO16;
			capture_value <= `ZERO16;
			carrier_timer <= `ZERO8;
			wide_timer <= `ZERO16;
			presc <= 3'h0;
			carrier_timer_output <= 1'b0;
			wide_timer_output_level <= 1'b0;
			pingpong_turn <= 1'b0;
			sync_wait <= 1'b0;
			demod_prev <= 1'b0;
			fall_flag <= 1'b0;
			rise_flag <= 1'b0;
			rdata <= `ZERO8;
			first_shared_pin <= 1'b0;
			second_shared_pin <= 1'b0;
			third_shared_pin <= 1'b0;
			carrier_timeout_irq <= 1'b0;
			carrier_capture_irq <= 1'b0;
			wide_timeout_irq <= 1'b0;
			wide_capture_irq <= 1'b0;
		end
		else if (clk_en)
		begin
			demod_prev <= demod;
			fall_flag <= next_fall;
			rise_flag <= next_rise;
			presc <= carrier_run ? presc + 3'h1 : 3'h0;
			// carrier timer: alternating high/low half periods
			if (wr_carrier && wdata[`B_RUN] && !carrier_run)
			begin
				carrier_timer <= carrier_high_count;
				carrier_timer_output <=
					timer_pair_common_control[`B_T8_INIT];
				sync_wait <= timer_sync_control[`B_SYNC_EN];
			end
			else if (sync_wait)
			begin
				if (wide_out)
					sync_wait <= 1'b0;
				presc <= 3'h0;
			end
			else if (carrier_run && !capture_mode && carrier_tick)
			begin
				if (carrier_timer == `ZERO8)
				begin
					carrier_timer_output <= !carrier_timer_output;
					carrier_timer <= carrier_timer_output ?
						carrier_low_count : carrier_high_count;
				end
				else
					carrier_timer <= carrier_timer - 8'h01;
			end
			// wide timer: transmit counts down, capture measures
			if (wr_wide && wdata[`B_RUN] && !wide_run)
			begin
				wide_timer <= wide_reload;
				wide_timer_output_level <=
					timer_pair_common_control[`B_T16_INIT];
				pingpong_turn <= 1'b0;
			end
			else if (wide_run && capture_mode)
			begin
				if (edge_hit)
				begin
					capture_value <= wide_timer;
					wide_timer <= `ZERO16;
				end
				else
					wide_timer <= wide_timer + `ONE16;
			end
			else if (wide_expire)
			begin
				wide_timer_output_level <= !wide_timer_output_level;
				wide_timer <= wide_reload;
				if (opsel == `OP_PINGPONG)
					pingpong_turn <= !pingpong_turn;
			end
			else if (wide_run && !capture_mode &&
				!(opsel == `OP_PINGPONG && !pingpong_turn))
				wide_timer <= wide_timer - `ONE16;
			// register writes
			if (wr_carrier)
			begin
				carrier_timer_control[`B_RUN] <= wdata[`B_RUN];
				carrier_timer_control[`B_SINGLE:`B_SINGLE] <=
					wdata[`B_SINGLE:`B_SINGLE];
				carrier_timer_control[`B_PRESC_HI:`B_PIN_SEL] <=
					wdata[`B_PRESC_HI:`B_PIN_SEL];
			end
			if (wr_carrier && wdata[`B_TIMEOUT])
				carrier_timer_control[`B_TIMEOUT] <= 1'b0;
			if (carrier_expire && carrier_timer_output)
			begin
				carrier_timer_control[`B_TIMEOUT] <= 1'b1;
				if (carrier_timer_control[`B_SINGLE])
					carrier_timer_control[`B_RUN] <= 1'b0;
				if (opsel == `OP_PINGPONG)
					pingpong_turn <= 1'b1;
			end
			if (opsel == `OP_PINGPONG && !pingpong_turn &&
				!capture_mode && carrier_run)
				wide_timer_output_level <= 1'b0;
			if (wr_common)
				timer_pair_common_control <= wdata;
			if (wr_wide)
			begin
				wide_timer_control[`B_RUN] <= wdata[`B_RUN];
				wide_timer_control[`B_SINGLE] <= wdata[`B_SINGLE];
				wide_timer_control[`B_PRESC_HI:`B_PIN_SEL] <=
					wdata[`B_PRESC_HI:`B_PIN_SEL];
			end
			if (wr_wide && wdata[`B_TIMEOUT])
				wide_timer_control[`B_TIMEOUT] <= 1'b0;
			if (wide_expire)
			begin
				wide_timer_control[`B_TIMEOUT] <= 1'b1;
				if (wide_timer_control[`B_SINGLE])
					wide_timer_control[`B_RUN] <= 1'b0;
			end
			if (wr && addr == {2'h0, `ADDR_SYNC_CTRL})
				timer_sync_control <= wdata;
			if (wr && addr == {1'b0, `ADDR_CARRIER_HI})
				carrier_high_count <= wdata;
			if (wr && addr == {1'b0, `ADDR_CARRIER_LO})
				carrier_low_count <= wdata;
			if (wr && addr == {1'b0, `ADDR_WIDE_RELOAD_HI})
				wide_reload[15:8] <= wdata;
			if (wr && addr == {1'b0, `ADDR_WIDE_RELOAD_LO})
				wide_reload[7:0] <= wdata;
			// register reads
			if (rd)
			begin
				case (addr)
					{2'h0, `ADDR_CARRIER_CTRL}: rdata <= carrier_timer_control;
					{2'h0, `ADDR_COMMON_CTRL}: rdata <= capture_mode ?
						{timer_pair_common_control[7:2], rise_flag,
						fall_flag} : timer_pair_common_control;
					{2'h0, `ADDR_WIDE_CTRL}: rdata <= wide_timer_control;
					{2'h0, `ADDR_SYNC_CTRL}: rdata <= timer_sync_control;
					{1'b0, `ADDR_CARRIER_HI}: rdata <= carrier_high_count;
					{1'b0, `ADDR_CARRIER_LO}: rdata <= carrier_low_count;
					{1'b0, `ADDR_WIDE_RELOAD_HI}: rdata <= wide_reload[15:8];
					{1'b0, `ADDR_WIDE_RELOAD_LO}: rdata <= wide_reload[7:0];
					`ADDR_CAPTURE_HI: rdata <= capture_value[15:8];
					`ADDR_CAPTURE_LO: rdata <= capture_value[7:0];
					default: rdata <= `ZERO8;
				endcase
			end
			else
				rdata <= `ZERO8;
			// pins and interrupt requests
			first_shared_pin <= carrier_timer_control[`B_PIN_SEL] ?
				carrier_timer_output : port_out_first;
			third_shared_pin <= wide_timer_control[`B_PIN_SEL] ?
				wide_out : port_out_third;
			second_shared_pin <= (!capture_mode &&
				timer_pair_common_control[`B_DEMOD_SEL]) ?
				combined : port_out_second;
			carrier_timeout_irq <= carrier_timer_control[`B_TIMEOUT] &
				carrier_timer_control[`B_TO_IE];
			carrier_capture_irq <= (rise_flag | fall_flag) &
				carrier_timer_control[`B_CAP_IE];
			wide_timeout_irq <= wide_timer_control[`B_TIMEOUT] &
				wide_timer_control[`B_TO_IE];
			wide_capture_irq <= (rise_flag | fall_flag) &
				wide_timer_control[`B_CAP_IE];
		end
	end
endmodule // ir_pulse_timer_control

// ### ir_timer_sva.sv
// port-level checker for the ir timer pair control block
// assumes clk_en held high; shadows track written control bytes
`timescale 1ns/10ps
module ir_timer_sva (
	input wire clk,
	input wire rst_b,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	input wire [7:0] rdata,
	input wire port_out_first,
	input wire port_out_third,
	input wire first_shared_pin,
	input wire third_shared_pin,
	input wire wide_timeout_irq
);
	reg [7:0] c0;
	reg [7:0] c1;
	reg [7:0] c2;
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			c0 <= 8'h00;
			c1 <= 8'h00;
			c2 <= 8'h00;
		end
		else if (wr)
		begin
			if (addr == 4'h0)
				c0 <= wdata;
			if (addr == 4'h1)
				c1 <= wdata;
			if (addr == 4'h2)
				c2 <= wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data not zero outside answer");
	a_unmapped_zero: assert property (rd && addr > 4'h9 |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	a_first_port: assert property (
		!c0[0] |=> first_shared_pin == $past(port_out_first))
		else $error("first pin not port value");
	a_third_port: assert property (
		!c2[0] |=> third_shared_pin == $past(port_out_third))
		else $error("third pin not port value");
	a_force_high: assert property (
		(c2[0] && !c1[7] && c1[3:2] == 2'h3) [*3] |-> third_shared_pin)
		else $error("wide output not forced high");
	a_force_low: assert property (
		(c2[0] && !c1[7] && c1[3:2] == 2'h2) [*3] |-> !third_shared_pin)
		else $error("wide output not forced low");
	a_wide_irq_gate: assert property (
		!c2[1] && !$past(c2[1]) |-> !wide_timeout_irq)
		else $error("wide timeout irq while disabled");
	a_ctrl0_read: assert property (
		rd && addr == 4'h0 |=> rdata[4:0] == $past(c0[4:0]))
		else $error("carrier control readback wrong");
	a_ctrl1_read: assert property (
		rd && addr == 4'h1 |=> rdata[7:2] == $past(c1[7:2]))
		else $error("common control readback wrong");
	cover property (rd && addr > 4'h9);
	cover property (wide_timeout_irq);
	cover property (third_shared_pin && c2[0]);
endmodule // ir_timer_sva

// ### ir_link_end.sv
// far-side model: ir receiver front end driving the demod inputs
// assumes fire is a one-cycle request; slow delays the edge
`timescale 1ns/10ps
module ir_link_end (
	input wire clk,
	input wire fire,
	input wire alt,
	input wire slow,
	output reg demod_input_primary = 1'b0,
	output reg demod_input_alternate = 1'b0
);
	integer wait_left = 0;
	reg pick = 1'b0;
	always @(posedge clk)
	begin
		if (fire)
		begin
			wait_left <= slow ? 6 : 1;
			pick <= alt;
		end
		else if (wait_left == 1)
		begin
			wait_left <= 0;
			if (pick)
				demod_input_alternate <= ~demod_input_alternate;
			else
				demod_input_primary <= ~demod_input_primary;
		end
		else if (wait_left > 1)
			wait_left <= wait_left - 1;
	end
endmodule // ir_link_end

// ### testbench.sv
// self-checking bench for the ir timer pair control block
// assumes the far-side model ir_link_end and the checker ir_timer_sva
`timescale 1ns/10ps
module testbench;
	reg clk, rst_b, wr, rd, po1, po2, po3, fire, alt, slow;
	reg [3:0] addr;
	reg [7:0] wdata, d;
	wire [7:0] rdata;
	wire p1, p2, p3, t8i, c8i, t16i, c16i, dp, da;
	integer mismatches, n_checks, i;
	ir_pulse_timer_control dut (.clk(clk), .rst_b(rst_b), .clk_en(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.demod_input_primary(dp), .demod_input_alternate(da),
		.port_out_first(po1), .port_out_second(po2), .port_out_third(po3),
		.first_shared_pin(p1), .second_shared_pin(p2),
		.third_shared_pin(p3), .carrier_timeout_irq(t8i),
		.carrier_capture_irq(c8i), .wide_timeout_irq(t16i),
		.wide_capture_irq(c16i));
	ir_link_end far (.clk(clk), .fire(fire), .alt(alt), .slow(slow),
		.demod_input_primary(dp), .demod_input_alternate(da));
	task chk(input [7:0] got, input [7:0] exp);
	begin
		n_checks = n_checks + 1;
		if (got !== exp)
		begin
			mismatches = mismatches + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task wr_reg(input [3:0] a, input [7:0] v);
	begin
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	end
	endtask
	task rd_reg(input [3:0] a, output [7:0] v);
	begin
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	end
	endtask
	task wait_bit(input [3:0] a, input integer b, output [7:0] v);
		integer k;
	begin
		v = 8'h00;
		for (k = 0; k < 40 && v[b] !== 1'b1; k = k + 1)
			rd_reg(a, v);
	end
	endtask
	task pulse(input a, input s);
	begin
		@(posedge clk);
		fire <= 1'b1;
		alt <= a;
		slow <= s;
		@(posedge clk);
		fire <= 1'b0;
	end
	endtask
	task t_reset;
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			rd_reg(i[3:0], d);
			chk(d, 8'h00);
		end
		rd_reg(4'hf, d);
		chk(d, 8'h00);
		$display("test reset done");
	end
	endtask
	task t_pins;
	begin
		for (i = 0; i < 2; i = i + 1)
		begin
			@(posedge clk);
			po1 <= ~i[0];
			po2 <= i[0];
			po3 <= ~i[0];
			repeat (2) @(posedge clk);
			#1;
			chk({5'h0, p3, p2, p1}, {5'h0, po3, po2, po1});
		end
		wr_reg(4'h2, 8'h01);
		for (i = 2; i < 4; i = i + 1)
		begin
			wr_reg(4'h1, {2'h1, 2'h1, i[1:0], 2'h0});
			repeat (3) @(posedge clk);
			#1;
			chk({6'h0, p3, p2}, {6'h0, i[0], i[0]});
		end
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h1, 8'h00);
		$display("test pins done");
	end
	endtask
	task t_ctrl;
	begin
		for (i = 0; i < 4; i = i + 1)
		begin
			wr_reg(4'h1, {2'h0, i[1:0], 4'h0});
			rd_reg(4'h1, d);
			chk(d, {2'h0, i[1:0], 4'h0});
			wr_reg(4'h0, {3'h0, i[1:0], 3'h6});
			rd_reg(4'h0, d);
			chk(d, {3'h0, i[1:0], 3'h6});
		end
		wr_reg(4'h0, 8'h00);
		wr_reg(4'h1, 8'h00);
		$display("test control done");
	end
	endtask
	task t_capture;
	begin
		wr_reg(4'h0, 8'h04);
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h1, 8'h90);
		wr_reg(4'h2, 8'h84);
		pulse(1'b0, 1'b0);
		wait_bit(4'h1, 1, d);
		chk(d & 8'h03, 8'h02);
		chk({6'h0, c16i, c8i}, 8'h03);
		wr_reg(4'h1, 8'hd2);
		rd_reg(4'h1, d);
		chk(d & 8'h03, 8'h00);
		chk({6'h0, c16i, c8i}, 8'h00);
		pulse(1'b1, 1'b1);
		wait_bit(4'h1, 1, d);
		chk(d & 8'h03, 8'h02);
		// both edges, 4-cycle filter: a 2-cycle glitch must vanish
		wr_reg(4'h1, 8'ha7);
		pulse(1'b0, 1'b0);
		pulse(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		rd_reg(4'h1, d);
		chk(d & 8'h03, 8'h00);
		pulse(1'b0, 1'b0);
		wait_bit(4'h1, 0, d);
		chk(d & 8'h03, 8'h01);
		wr_reg(4'h2, 8'h00);
		wr_reg(4'h1, 8'h00);
		$display("test capture done");
	end
	endtask
	task run_to(input [3:0] a, input [7:0] on);
	begin
		wr_reg(a, on);
		wait_bit(a, 5, d);
		chk(d & 8'ha0, 8'ha0);
		chk({6'h0, t16i, t8i}, {6'h0, a[1], !a[1]});
		wr_reg(a, 8'h22);
		rd_reg(a, d);
		chk(d & 8'ha0, 8'h00);
	end
	endtask
	task t_timeout;
	begin
		wr_reg(4'h4, 8'h02);
		wr_reg(4'h5, 8'h02);
		run_to(4'h0, 8'h82);
		wr_reg(4'h6, 8'h00);
		wr_reg(4'h7, 8'h04);
		wr_reg(4'h2, 8'hc2);
		wait_bit(4'h2, 5, d);
		chk(d & 8'h20, 8'h20);
		chk({7'h0, t16i}, 8'h01);
		wr_reg(4'h2, 8'h22);
		rd_reg(4'h2, d);
		chk(d & 8'ha0, 8'h00);
		run_to(4'h2, 8'h82);
		$display("test timeout done");
	end
	endtask
	task t_modes;
	begin
		// wide output forced low holds the synced carrier back
		wr_reg(4'h1, 8'h08);
		wr_reg(4'h3, 8'h80);
		wr_reg(4'h0, 8'hd8);
		repeat (60) @(posedge clk);
		rd_reg(4'h0, d);
		chk(d & 8'h20, 8'h00);
		wr_reg(4'h1, 8'h0c);
		repeat (30) @(posedge clk);
		rd_reg(4'h0, d);
		chk(d & 8'h20, 8'h00);
		wait_bit(4'h0, 5, d);
		chk(d & 8'he0, 8'h60);
		wr_reg(4'h0, 8'h20);
		wr_reg(4'h1, 8'h00);
		wr_reg(4'h3, 8'h00);
		$display("test modes done");
	end
	endtask
	task wrap_up;
	begin
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial
	begin
		rst_b = 1'b0;
		{wr, rd, po1, po2, po3, fire, alt, slow} = 8'h00;
		addr = 4'h0;
		wdata = 8'h00;
		mismatches = 0;
		n_checks = 0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		t_reset;
		t_pins;
		t_ctrl;
		t_capture;
		t_timeout;
		t_modes;
		wrap_up;
	end
	initial
	begin
		#2000000;
		mismatches = mismatches + 1;
		wrap_up;
	end
endmodule // testbench
bind ir_pulse_timer_control ir_timer_sva chk_i (.clk(clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.port_out_first(port_out_first), .port_out_third(port_out_third),
	.first_shared_pin(first_shared_pin),
	.third_shared_pin(third_shared_pin),
	.wide_timeout_irq(wide_timeout_irq));
